// *** hisr_top.sv ***
// host-visible interrupt/status register of the adapter system interface
// the host reaches it over the direct i/o strobes; the internal processor
// drives the status events and clears below
`timescale 1ns/1ps
`default_nettype none
module hisr_top
    import hisr_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire logic                   dio_rd,
    input  wire logic                   dio_wr,
    input  wire logic [HISR_WORD_W-1:0] dio_wdata,
    output logic      [HISR_WORD_W-1:0] dio_rdata,
    output logic                        dio_rvalid,
    input  wire logic [HISR_REQ_W-1:0]  cp_req_clear,
    input  wire logic                   cp_diag_done,
    input  wire logic                   cp_diag_fail,
    input  wire logic                   cp_init_done,
    input  wire logic                   cp_init_fail,
    input  wire logic [3:0]             cp_error_code,
    input  wire logic                   cp_adapter_check,
    input  wire logic                   cp_ring_status,
    input  wire logic                   cp_cmd_block_free,
    input  wire logic                   cp_cmd_status,
    input  wire logic                   cp_rx_status,
    input  wire logic                   cp_tx_status,
    input  wire logic                   cp_reason_taken,
    output logic      [HISR_REQ_W-1:0]  req_bits,
    output logic                        host_interrupt_line
);
    hisr_phase_t                 phase;
    hisr_phase_t                 next_phase;
    logic                        intr;
    logic                        next_intr;
    logic [HISR_NREASON-1:0]     pend;
    logic [HISR_NREASON-1:0]     next_pend;
    logic [HISR_NREASON-1:0]     evt;
    logic [2:0]                  cur_code;
    logic [2:0]                  shown_code;
    logic [2:0]                  next_shown_code;
    logic                        any_pend;
    logic [3:0]                  ecode;
    logic [3:0]                  next_ecode;
    logic                        sw_reset;
    logic [HISR_WORD_W-1:0]      word;
    logic [HISR_WORD_W-1:0]      next_rdata;

    // a write of ff in the low byte is the software reset request
    assign sw_reset = dio_wr && (dio_wdata[7:0] == 8'hff);

    hisr_req_bits #(
        .N          (HISR_REQ_W)
    ) u_req (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .host_wr    (dio_wr),
        .host_wdata (dio_wdata[HISR_REQ_W-1:0]),
        .cp_clear   (cp_req_clear),
        .req        (req_bits)
    );

    hisr_reason_pick u_pick (
        .pend (pend),
        .any  (any_pend),
        .code (cur_code)
    );

    assign evt = {cp_tx_status, cp_rx_status, cp_cmd_status,
                  cp_cmd_block_free, cp_ring_status, 1'b0, cp_adapter_check};
    // codes: 0 2 ring 3 free 4 cmd
    // 5 rx 6 tx slot 1 is tied off

    // phase: diagnostics -> ready -> running, or failed
    always_comb
    begin
        next_phase = phase;
        next_ecode = ecode;
        case (phase)
            HISR_DIAG:
            begin
                if (cp_diag_fail)
                begin
                    next_phase = HISR_FAIL;
                    next_ecode = cp_error_code;
                end
                else if (cp_diag_done)
                    next_phase = HISR_READY;
            end
            HISR_READY:
            begin
                if (cp_init_fail)
                begin
                    next_phase = HISR_FAIL;
                    next_ecode = cp_error_code;
                end
                else if (cp_init_done)
                    next_phase = HISR_RUN;
            end
            HISR_RUN:  next_phase = HISR_RUN;
            HISR_FAIL: next_phase = HISR_FAIL;
            default:   next_phase = HISR_DIAG;
        endcase
        // software reset reruns diagnostics
        if (sw_reset)
        begin
            next_phase = HISR_DIAG;
            next_ecode = HISR_ECODE_RST;
        end
    end

    // reason pending bits and host interrupt flag
    always_comb
    begin
        next_pend       = pend;
        next_intr       = intr;
        next_shown_code = shown_code;
        // lowest pending reason (cur_code) retires once the processor sees it acknowledged
        if (cp_reason_taken && intr == 1'b0 && any_pend)
            next_pend[cur_code] = 1'b0;
        next_pend = next_pend | evt;
        // host write of zero to bit 8 clears; writing one does nothing
        if (dio_wr && !dio_wdata[HISR_BIT_INTR])
            next_intr = 1'b0;
        // a software reset forgets the last code unless bit 8 still shows it
        if (sw_reset && !intr)
            next_shown_code = HISR_RSN_CHECK;
        // new interrupt only raised once host cleared the last one; the code
        // is picked from next_pend so a reason retired now is left out and one landing now counts
        if (!intr && (|next_pend) && !(dio_wr && !dio_wdata[HISR_BIT_INTR]))
        begin
            next_intr = 1'b1;
            for (int k = HISR_NREASON - 1; k >= 0; k--)
            begin
                if (next_pend[k] && HISR_RSN_VALID[k])
                    next_shown_code = 3'(k);
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            phase      <= HISR_DIAG;
            ecode      <= HISR_ECODE_RST;
            pend       <= '0;
            intr       <= 1'b0;
            shown_code <= HISR_RSN_CHECK;
        end
        else
        begin
            phase      <= next_phase;
            ecode      <= next_ecode;
            pend       <= next_pend;
            intr       <= next_intr;
            shown_code <= next_shown_code;
        end
    end

    assign host_interrupt_line = intr;

    // assemble the read word; upper bits are processor-owned except that a host software reset write also moves them
    always_comb
    begin
        word                  = '0;
        word[HISR_REQ_W-1:0]  = req_bits;
        word[HISR_BIT_INTR]   = intr;
        word[HISR_BIT_INIT]   = (phase == HISR_READY);
        word[HISR_BIT_TEST]   = (phase == HISR_DIAG) ||
                                (phase == HISR_FAIL);
        word[HISR_BIT_ERR]    = (phase == HISR_FAIL);
        if (phase == HISR_FAIL)
            word[HISR_WORD_W-1:HISR_CODE_LSB] = ecode;
        else
            word[HISR_WORD_W-1:HISR_CODE_LSB] = {1'b0, shown_code};
    end

    always_comb
    begin
        next_rdata = dio_rd ? word : dio_rdata;
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dio_rdata  <= '0;
            dio_rvalid <= 1'b0;
        end
        else
        begin
            dio_rdata  <= next_rdata;
            dio_rvalid <= dio_rd;
        end
    end

    chk_read_word: assert property (@(posedge clk_sys) disable iff (srst)
        dio_rd |=> (dio_rvalid && dio_rdata == $past(word)))
        else $error("read word not returned next cycle");
    chk_req_shown: assert property (@(posedge clk_sys) disable iff (srst)
        word[7:0] == req_bits)
        else $error("request bits not visible");
    chk_intr_line: assert property (@(posedge clk_sys) disable iff (srst)
        host_interrupt_line == word[HISR_BIT_INTR])
        else $error("bit 8 and interrupt line differ");
    chk_intr_sticky: assert property (@(posedge clk_sys) disable iff (srst)
        (intr && !(dio_wr && !dio_wdata[HISR_BIT_INTR])) |=> intr)
        else $error("interrupt cleared without host write");
    chk_intr_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (intr && dio_wr && !dio_wdata[HISR_BIT_INTR]) |=> !intr)
        else $error("host zero write did not clear bit 8");
    chk_init_flow: assert property (@(posedge clk_sys) disable iff (srst)
        (phase == HISR_READY && cp_init_done && !cp_init_fail && !sw_reset)
        |=> !word[HISR_BIT_INIT])
        else $error("init bit not cleared on init done");
    chk_test_clear: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(word[HISR_BIT_INIT]) |-> !word[HISR_BIT_TEST])
        else $error("test bit still set when ready rises");
    chk_err_code: assert property (@(posedge clk_sys) disable iff (srst)
        (phase == HISR_DIAG && cp_diag_fail && !sw_reset)
        |=> (word[HISR_BIT_ERR] && word[15:12] == $past(cp_error_code)))
        else $error("error code not latched on failure");
    chk_code_legal: assert property (@(posedge clk_sys) disable iff (srst)
        (phase != HISR_FAIL) |-> (shown_code != 3'h1 && shown_code != 3'h7))
        else $error("undefined reason code reported");

    // every event lands in the pending slot of its own code; a retire in
    // the same cycle must not swallow a fresh event
    chk_evt_check: assert property (@(posedge clk_sys) disable iff (srst)
        cp_adapter_check |=> pend[HISR_RSN_CHECK])
        else $error("adapter check reason not pending");

    chk_evt_ring: assert property (@(posedge clk_sys) disable iff (srst)
        cp_ring_status |=> pend[HISR_RSN_RING])
        else $error("ring status reason not pending");

    chk_evt_free: assert property (@(posedge clk_sys) disable iff (srst)
        cp_cmd_block_free |=> pend[HISR_RSN_SCB])
        else $error("command block free reason not pending");

    chk_evt_cmd: assert property (@(posedge clk_sys) disable iff (srst)
        cp_cmd_status |=> pend[HISR_RSN_CMD])
        else $error("command status reason not pending");

    chk_evt_rx: assert property (@(posedge clk_sys) disable iff (srst)
        cp_rx_status |=> pend[HISR_RSN_RX])
        else $error("receive status reason not pending");

    chk_evt_tx: assert property (@(posedge clk_sys) disable iff (srst)
        cp_tx_status |=> pend[HISR_RSN_TX])
        else $error("transmit status reason not pending");

    chk_slot_one: assert property (@(posedge clk_sys) disable iff (srst)
        pend[1] == 1'b0)
        else $error("undefined reason slot became pending");

    // the code latched at the raise is the lowest pending one and then holds
    chk_raise_lowest: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(intr) |-> (shown_code == cur_code))
        else $error("raised code is not the lowest pending");

    chk_code_held: assert property (@(posedge clk_sys) disable iff (srst)
        intr |=> (!intr || $stable(shown_code)))
        else $error("reason code changed while bit 8 set");

    chk_line_raise: assert property (@(posedge clk_sys) disable iff (srst)
        (!intr && (pend != '0 || evt != '0) && !cp_reason_taken &&
         !(dio_wr && !dio_wdata[HISR_BIT_INTR])) |=> intr)
        else $error("pending reason did not raise bit 8");

    chk_no_self_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (intr && !dio_wr) |=> intr)
        else $error("bit 8 dropped with no host write");

    // status flags follow the processor; host writes move them only by the software reset
    chk_init_fail: assert property (@(posedge clk_sys) disable iff (srst)
        (phase == HISR_READY && cp_init_fail && !sw_reset)
        |=> (word[HISR_BIT_ERR] &&
             word[HISR_WORD_W-1:HISR_CODE_LSB] == $past(cp_error_code)))
        else $error("init failure not flagged");

    chk_err_test: assert property (@(posedge clk_sys) disable iff (srst)
        word[HISR_BIT_ERR] |-> word[HISR_BIT_TEST])
        else $error("error bit shown without test bit");

    chk_ready_rise: assert property (@(posedge clk_sys) disable iff (srst)
        (phase == HISR_DIAG && cp_diag_done && !cp_diag_fail && !sw_reset)
        |=> (word[HISR_BIT_INIT] && !word[HISR_BIT_TEST]))
        else $error("ready did not replace test bit");

    chk_soft_rerun: assert property (@(posedge clk_sys) disable iff (srst)
        sw_reset |=> (word[HISR_BIT_TEST] && !word[HISR_BIT_INIT] &&
                      !word[HISR_BIT_ERR]))
        else $error("software reset did not restart diagnostics");

    chk_upper_ro: assert property (@(posedge clk_sys) disable iff (srst)
        (dio_wr && !sw_reset && !cp_diag_done && !cp_diag_fail &&
         !cp_init_done && !cp_init_fail)
        |=> (word[HISR_BIT_ERR:HISR_BIT_INIT] == $past(word[HISR_BIT_ERR:HISR_BIT_INIT])))
        else $error("host write moved a read-only status bit");

    // read strobe answers once; the data then stays until the next read
    chk_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        !dio_rd |=> !dio_rvalid)
        else $error("read valid without a read strobe");

    chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !dio_rd |=> $stable(dio_rdata))
        else $error("read data changed without a read");
endmodule
`default_nettype wire

// *** hisr_pkg.sv ***
// package for the host interrupt/status register block
// assumes one 100 MHz clock domain with a synchronous active-high reset
// How it works
// - host read returns one 16-bit word
// - bits 0-7 show eight request bits
// - bit 8 shows pending host interrupt
// - only the host clears bit 8
// - bit 9 set after diagnostics, cleared after init
// - bit 10 set on reset, cleared when ready
// - bit 11 flags diagnostic or init error
// - lowest pending reason code reported first
// - code 000 means adapter check
// - code 010 means ring status update
// - code 100 means other command status
// - code 101 means receive status
// - code 110 means transmit status
// - on errors bits 12-15 hold error code
// - host sets request bits, processor clears them
// - write zero to bit 8 clears interrupt
// - bits 1-7 act only with bit 0
// - bits 9-15 read-only, processor controlled; a host software reset write (ff in the low byte) also moves them
package hisr_pkg;
    localparam int          HISR_WORD_W    = 16;
    localparam int          HISR_REQ_W     = 8;
    localparam int          HISR_NREASON   = 7;
    localparam int          HISR_BIT_INTR  = 8;
    localparam int          HISR_BIT_INIT  = 9;
    localparam int          HISR_BIT_TEST  = 10;
    localparam int          HISR_BIT_ERR   = 11;
    localparam int          HISR_CODE_LSB  = 12;
    localparam logic [7:0]  HISR_REQ_RST   = 8'h00;
    localparam logic [3:0]  HISR_ECODE_RST = 4'h0;
    localparam logic [2:0]  HISR_RSN_CHECK = 3'h0;
    localparam logic [2:0]  HISR_RSN_RING  = 3'h2;
    localparam logic [2:0]  HISR_RSN_SCB   = 3'h3;
    localparam logic [2:0]  HISR_RSN_CMD   = 3'h4;
    localparam logic [2:0]  HISR_RSN_RX    = 3'h5;
    localparam logic [2:0]  HISR_RSN_TX    = 3'h6;
    localparam logic [6:0]  HISR_RSN_VALID = 7'h7d;
    typedef enum logic [1:0] {
        HISR_DIAG,
        HISR_READY,
        HISR_RUN,
        HISR_FAIL
    } hisr_phase_t;
endpackage

// *** hisr_req_bits.sv ***
// eight host-to-adapter request bits: host sets, processor clears
// assumes write strobes are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`default_nettype none
module hisr_req_bits
    import hisr_pkg::*;
#(
    parameter int N = HISR_REQ_W
)(
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         host_wr,
    input  wire logic [N-1:0] host_wdata,
    input  wire logic [N-1:0] cp_clear,
    output logic      [N-1:0] req
);
    logic [N-1:0] next_req;
    logic         arm;

    // without bit 0 the whole request byte is ignored
    assign arm = host_wr & host_wdata[0];

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_bit
            always_comb
            begin
                next_req[i] = req[i];
                if (cp_clear[i])
                    next_req[i] = 1'b0;
                // a host set in the clearing cycle wins
                if (arm && host_wdata[i])
                    next_req[i] = 1'b1;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            req <= HISR_REQ_RST;
        else
            req <= next_req;
    end

    chk_host_no_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (req != '0 && cp_clear == '0) |=> ((req & $past(req)) == $past(req)))
        else $error("request bit dropped without processor clear");
    chk_arm_needed: assert property (@(posedge clk_sys) disable iff (srst)
        (host_wr && !host_wdata[0] && cp_clear == '0) |=> (req == $past(req)))
        else $error("request bits changed without bit 0");
endmodule
`default_nettype wire

// *** hisr_reason_pick.sv ***
// priority pick of the pending interrupt reason, lowest code wins
// pure combinational; pending vector indexed by code value
`timescale 1ns/1ps
`default_nettype none
module hisr_reason_pick
    import hisr_pkg::*;
(
    input  wire logic [HISR_NREASON-1:0] pend,
    output logic                         any,
    output logic      [2:0]              code
);
    always_comb
    begin
        any  = 1'b0;
        code = HISR_RSN_CHECK;
        // walk downward so the last hit is the lowest code
        for (int k = HISR_NREASON - 1; k >= 0; k--)
        begin
            if (pend[k] && HISR_RSN_VALID[k])
            begin
                any  = 1'b1;
                code = 3'(k);
            end
        end
    end
endmodule
`default_nettype wire

// *** hisr_host_model.sv ***
// host processor model: direct i/o reads and writes of the status word
// assumes the bench calls its tasks; strobes move 1 ns after clk_sys rises
`timescale 1ns/1ps
`default_nettype none
module hisr_host_model
    import hisr_pkg::*;
(
    input  wire logic                   clk_sys,
    output logic                        dio_rd,
    output logic                        dio_wr,
    output logic      [HISR_WORD_W-1:0] dio_wdata,
    input  wire logic [HISR_WORD_W-1:0] dio_rdata,
    input  wire logic                   dio_rvalid
);
    initial
    begin
        dio_rd    = 1'b0;
        dio_wr    = 1'b0;
        dio_wdata = 16'h0000;
    end
    // the host sets request bits, clears bit 8 by writing a zero and requests a software reset with ff in the low byte
    task automatic write_word(input logic [HISR_WORD_W-1:0] w);
        @(posedge clk_sys);
        #1;
        dio_wr    = 1'b1;
        dio_wdata = w;
        @(posedge clk_sys);
        #1;
        dio_wr    = 1'b0;
        // a released data bus must not keep showing the old word
        dio_wdata = ~w;
    endtask
    task automatic read_word(output logic [HISR_WORD_W-1:0] r, output logic v);
        @(posedge clk_sys);
        #1;
        dio_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        dio_rd = 1'b0;
        v      = dio_rvalid;
        r      = dio_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb_host_interrupt_status_register.sv ***
// self-checking bench of the host interrupt/status register
// assumes hisr_top and the host model; processor side is driven here
`timescale 1ns/1ps
`default_nettype none
module tb_host_interrupt_status_register;
    import hisr_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic        dio_rd;
    logic        dio_wr;
    logic [15:0] dio_wdata;
    logic [15:0] dio_rdata;
    logic        dio_rvalid;
    logic [7:0]  clr     = 8'h00;
    logic [10:0] cpv     = 11'h000;
    logic [3:0]  ecode   = 4'h0;
    logic [7:0]  req_bits;
    logic        line;
    logic [15:0] rd;
    logic [15:0] w;
    logic        v;
    logic [7:0]  req_m   = 8'h00;
    logic [6:0]  pend_m  = 7'h7d;
    logic [31:0] r32;
    integer      seed    = 32'h5a72;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc     = 0;
    always #5 clk_sys = ~clk_sys;
    hisr_host_model host (.clk_sys(clk_sys), .dio_rd(dio_rd), .dio_wr(dio_wr),
        .dio_wdata(dio_wdata), .dio_rdata(dio_rdata), .dio_rvalid(dio_rvalid));
    hisr_top dut (.clk_sys(clk_sys), .srst(srst), .dio_rd(dio_rd), .dio_wr(dio_wr),
        .dio_wdata(dio_wdata), .dio_rdata(dio_rdata), .dio_rvalid(dio_rvalid),
        .cp_req_clear(clr), .cp_diag_done(cpv[7]), .cp_diag_fail(cpv[8]),
        .cp_init_done(cpv[9]), .cp_init_fail(cpv[10]), .cp_error_code(ecode),
        .cp_adapter_check(cpv[0]), .cp_ring_status(cpv[1]),
        .cp_cmd_block_free(cpv[2]), .cp_cmd_status(cpv[3]), .cp_rx_status(cpv[4]),
        .cp_tx_status(cpv[5]), .cp_reason_taken(cpv[6]), .req_bits(req_bits),
        .host_interrupt_line(line));
    function automatic logic [7:0] exp_req(input logic [7:0] q, input logic [15:0] d);
        return d[0] ? (q | d[7:0]) : q;
    endfunction
    function automatic logic [2:0] low_code(input logic [6:0] p);
        logic [2:0] r;
        r = 3'h7;
        for (int c = 6; c >= 0; c--)
            if (p[c])
                r = 3'(c);
        return r;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic cmp1(input string n, input logic e, input logic g);
        cmp16(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic pulse(input logic [10:0] p);
        @(posedge clk_sys);
        #1;
        cpv = p;
        @(posedge clk_sys);
        #1;
        cpv = 11'h000;
    endtask
    task automatic wait_line();
        for (int n = 0; n < 20 && line !== 1'b1; n++)
            @(posedge clk_sys);
        #1;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        host.read_word(rd, v);
        cmp1("rvalid", 1'b1, v);
        cmp16("reset word", 16'h0400, rd);
        repeat (12)
        begin
            r32 = $random(seed);
            w = r32[15:0] | 16'h0100;
            // an all-ones low byte is a software reset, kept for later
            if (w[7:0] == 8'hff)
                w[7:0] = 8'hfd;
            req_m = exp_req(req_m, w);
            host.write_word(w);
            cmp16("req bits", {8'h00, req_m}, {8'h00, req_bits});
            clr = r32[23:16];
            @(posedge clk_sys);
            #1;
            clr = 8'h00;
            req_m = req_m & ~r32[23:16];
            host.read_word(rd, v);
            cmp16("req word", {8'h04, req_m}, rd);
        end
        pulse(11'h080);
        host.read_word(rd, v);
        cmp16("ready word", {8'h02, req_m}, rd);
        pulse(11'h03f);
        for (int i = 0; i < 6; i++)
        begin
            wait_line();
            cmp1("line up", 1'b1, line);
            host.write_word(16'h0100);
            cmp1("line held", 1'b1, line);
            host.read_word(rd, v);
            cmp16("reason", {1'b0, low_code(pend_m), 4'h3, req_m}, rd);
            pend_m[low_code(pend_m)] = 1'b0;
            host.write_word(16'h0000);
            cpv = 11'h040;
            cmp1("line clear", 1'b0, line);
            @(posedge clk_sys);
            #1;
            cpv = 11'h000;
        end
        repeat (4) @(posedge clk_sys);
        #1;
        cmp1("all retired", 1'b0, line);
        pulse(11'h200);
        host.read_word(rd, v);
        // the last code shown stays latched once bit 8 is cleared
        cmp16("run word", {1'b0, HISR_RSN_TX, 4'h0, req_m}, rd);
        for (int k = 0; k < 2; k++)
        begin
            host.write_word(16'h00ff);
            host.read_word(rd, v);
            cmp16("soft reset", 16'h0400, rd & 16'hff00);
            r32 = $random(seed);
            ecode = r32[3:0];
            if (k == 1)
                pulse(11'h080);
            pulse(k == 1 ? 11'h400 : 11'h100);
            host.read_word(rd, v);
            cmp16("fail word", {ecode, 4'hc, 8'h00}, rd & 16'hff00);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
